// file: tdc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Host side: per-phase command drivers
// ************************************************************
module tdc_host_model (
  // Clock
  input wire logic mclk_i,
  // Phase commands {c,b,a}
  output logic [2:0] high_side_command_n_o,
  output logic [2:0] low_side_command_o
);
  // Idle levels equal the pull-up and pull-down of undriven pins
  initial begin
    high_side_command_n_o = 3'h7;
    low_side_command_o = 3'h0;
  end
  // Request levels for one phase, changed just after a clock edge
  task automatic cmd(input int ph, input logic hs_req, input logic ls_req);
    @(posedge mclk_i);
    high_side_command_n_o[ph] <= ~hs_req;
    low_side_command_o[ph] <= ls_req;
  endtask : cmd
endmodule : tdc_host_model
`default_nettype wire

// file: tdc_map.svh
`ifndef TDC_MAP_SVH
`define TDC_MAP_SVH
// ************************************************************
// Register offsets (byte addresses, word aligned)
// ************************************************************
`define TDC_OFS_DEADTIME 8'h00
`define TDC_OFS_CALIB 8'h04
`define TDC_OFS_MODE 8'h08
`define TDC_OFS_FMASK 8'h0c
`define TDC_OFS_STATUS 8'h10
`define TDC_OFS_INT_CLR 8'h14
`define TDC_OFS_INT_EN 8'h18
`define TDC_OFS_UNLOCK 8'h1c
`define TDC_OFS_GATES 8'h20
// ************************************************************
// Fields and values
// ************************************************************
`define TDC_MODE_SIMUL 0
`define TDC_MODE_DESAT 1
`define TDC_MODE_ZERO_DT 2
`define TDC_MODE_LOCK 3
`define TDC_UNLOCK_KEY 32'h0000_5a3c
`define TDC_DT_RESET 8'h14
`define TDC_CAL_RESET 8'h80
`define TDC_DT_STEP_NS 50
`define TDC_DT_MAX_NS 12000
`define TDC_CLK_NS 25
`define TDC_DT_STEP_CYC ((`TDC_DT_STEP_NS + `TDC_CLK_NS - 1) / `TDC_CLK_NS)
`define TDC_DT_MAX_STEPS (`TDC_DT_MAX_NS / `TDC_DT_STEP_NS)
`define TDC_BLANK_NS 500
`define TDC_BLANK_CYC (`TDC_BLANK_NS / `TDC_CLK_NS)
`endif

// file: tdc_phase.sv
`timescale 1ns/1ps
`default_nettype none
`include "tdc_map.svh"
// One phase: edge-sensitive commands, dead-time interlock, blanking
module tdc_phase (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // Configuration
  input wire logic step_i,          // 50 ns tick
  input wire tdc_pkg::tdc_dt_type dt_i,
  input wire logic simul_i,
  input wire logic en_i,
  // Phase bundle
  tdc_phase_if.chan ph
);
  import tdc_pkg::*;
  logic hs_d_reg;                   // Previous command levels
  logic ls_d_reg;
  logic [7:0] dt_reg;               // Dead-time steps remaining
  logic [4:0] blank_reg;            // Blanking cycles remaining
  logic hs_req_reg;                 // Pending wanted switch
  logic ls_req_reg;
  logic hs_g_reg;
  logic ls_g_reg;
  logic seen_reg;
  logic hs_rise;
  logic ls_rise;
  logic hs_fall;
  logic ls_fall;
  logic dt_done;
  assign hs_rise = hs_d_reg & ~ph.hs_cmd_n;
  assign hs_fall = ~hs_d_reg & ph.hs_cmd_n;
  assign ls_rise = ~ls_d_reg & ph.ls_cmd;
  assign ls_fall = ls_d_reg & ~ph.ls_cmd;
  assign dt_done = (dt_reg == 8'h00);
  // Edge history; reset values mean inactive
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      hs_d_reg <= 1'b1;
      ls_d_reg <= 1'b0;
    end else begin
      hs_d_reg <= ph.hs_cmd_n;
      ls_d_reg <= ph.ls_cmd;
    end
  end
  // Dead-time counter restarts on any turn-off of either switch, except in simul mode
  always_ff @(posedge mclk_i) begin
    if (reset_i || !en_i) begin
      dt_reg <= 8'h00;                              // see (RULE17)
    end else if ((hs_g_reg && (hs_fall || ls_rise) && !simul_i) ||
                 (ls_g_reg && (ls_fall || hs_rise) && !simul_i)) begin
      dt_reg <= dt_i;                               // see (RULE10)
    end else if (!dt_done && step_i) begin
      dt_reg <= dt_reg - 8'h01;
    end
  end
  // Pending requests follow command edges
  always_ff @(posedge mclk_i) begin
    if (reset_i || !en_i) begin
      hs_req_reg <= 1'b0;
      ls_req_reg <= 1'b0;
    end else begin
      // A leading edge drops the other side's pending request; not in
      // simul mode, where both may be wanted at once
      if (hs_rise) hs_req_reg <= 1'b1;
      else if (hs_fall || (ls_rise && !simul_i)) hs_req_reg <= 1'b0; // see (RULE8)
      if (ls_rise) ls_req_reg <= 1'b1;
      else if (ls_fall || (hs_rise && !simul_i)) ls_req_reg <= 1'b0; // see (RULE8)
    end
  end
  // Gates: leading edge drops the complement at once, turn-on waits
  always_ff @(posedge mclk_i) begin
    if (reset_i || !en_i) begin
      hs_g_reg <= 1'b0;                             // see (RULE17)
      ls_g_reg <= 1'b0;
    end else if (simul_i) begin
      // Both may conduct; no interlock
      hs_g_reg <= hs_req_reg && seen_reg;           // see (RULE16)
      ls_g_reg <= ls_req_reg;
    end else begin
      if (hs_fall || ls_rise) hs_g_reg <= 1'b0;     // see (RULE8)
      // A pending low-side request wins a tie, so both never start together
      else if (hs_req_reg && !ls_req_reg && !ls_g_reg && dt_done && seen_reg) begin
        hs_g_reg <= 1'b1;                           // see (RULE9) see (RULE11) see (RULE12)
      end
      if (ls_fall || hs_rise) ls_g_reg <= 1'b0;     // see (RULE8)
      else if (ls_req_reg && !hs_g_reg && dt_done) begin
        ls_g_reg <= 1'b1;                           // see (RULE11)
      end
    end
  end
  // Bootstrap guard: low side must conduct once after enable
  always_ff @(posedge mclk_i) begin
    if (reset_i || !en_i) seen_reg <= 1'b0;
    else if (ls_g_reg) seen_reg <= 1'b1;            // see (RULE16)
  end
  // Current-limit blanking after every input change, off in simul mode
  always_ff @(posedge mclk_i) begin
    if (reset_i || simul_i) begin
      blank_reg <= 5'h00;                           // see (RULE3)
    end else if (hs_rise || hs_fall || ls_rise || ls_fall) begin
      blank_reg <= 5'(`TDC_BLANK_CYC);              // see (RULE13)
    end else if (blank_reg != 5'h00) begin
      blank_reg <= blank_reg - 5'h01;
    end
  end
  assign ph.hs_gate = hs_g_reg;
  assign ph.ls_gate = ls_g_reg;
  assign ph.blank = (blank_reg != 5'h00);
  assign ph.ls_seen = seen_reg;
  // ************************************************************
  // Checks
  // ************************************************************
  never_both_a: assert property (@(posedge mclk_i) disable iff (reset_i) // see (RULE11)
    !simul_i |-> !(hs_g_reg && ls_g_reg)) else $error("both gates on");
  edge_off_a: assert property (@(posedge mclk_i) disable iff (reset_i) // see (RULE8)
    (!simul_i && hs_rise && en_i) |=> !ls_g_reg) else $error("complement not off");
  hs_guard_a: assert property (@(posedge mclk_i) disable iff (reset_i) // see (RULE16)
    $rose(hs_g_reg) |-> $past(seen_reg)) else $error("hs before ls");
  dt_wait_a: assert property (@(posedge mclk_i) disable iff (reset_i) // see (RULE9)
    (!simul_i && $rose(hs_g_reg)) |-> $past(dt_done)) else $error("dead-time cut");
  dt_load_a: assert property (@(posedge mclk_i) disable iff (reset_i) // see (RULE10)
    (en_i && !simul_i && ls_g_reg && hs_rise) |=> dt_reg == $past(dt_i))
    else $error("dead-time not started");
  blank_a: assert property (@(posedge mclk_i) disable iff (reset_i) // see (RULE13)
    (!simul_i && ls_rise) |=> ph.blank) else $error("no blanking");
  cv_hs_on_c: cover property (@(posedge mclk_i) $rose(hs_g_reg));
  cv_swap_c: cover property (@(posedge mclk_i) ls_g_reg ##[1:600] hs_g_reg);
endmodule : tdc_phase
`default_nettype wire

// file: tdc_phase_if.sv
`timescale 1ns/1ps
`default_nettype none
// Bundle between the top and one phase channel
interface tdc_phase_if;
  logic hs_cmd_n;     // High-side command, active low
  logic ls_cmd;       // Low-side command
  logic hs_gate;      // High-side gate-on request
  logic ls_gate;      // Low-side gate-on request
  logic blank;        // Low-side current-limit blanking active
  logic ls_seen;      // Low side switched on since enable
  modport ctrl (output hs_cmd_n, output ls_cmd, input hs_gate, input ls_gate,
    input blank, input ls_seen);
  modport chan (input hs_cmd_n, input ls_cmd, output hs_gate, output ls_gate,
    output blank, output ls_seen);
endinterface : tdc_phase_if
`default_nettype wire

// file: tdc_pkg.sv
package tdc_pkg;
  // Dead-time setting in 50 ns steps, 0..255, clamped to 240 in use
  typedef logic [7:0] tdc_dt_type;
  // Per-phase switch state
  typedef enum logic [1:0] {TDC_OFF, TDC_WAIT_HS, TDC_WAIT_LS} tdc_phase_type;
endpackage : tdc_pkg

// file: tdc_top.sv
// Design decisions made here: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "tdc_map.svh"
// Overview of operation
// (RULE1) Dead-time programmable, 50 ns steps, 0-12 us
// (RULE2) Host calibrates dead-time through register port
// (RULE3) Simultaneous conduction disables blanking delay
// (RULE4) Simultaneous mode settable once per reset
// (RULE5) Modes selectable, then locked by command
// (RULE6) Each fault source reported or suppressed
// (RULE7) Status registers readable by host
// (RULE8) Leading edge turns complement off immediately
// (RULE9) Commanded switch on after dead-time
// (RULE10) Dead-time starts at any turn-off
// (RULE11) Complement blocked until dead-time elapses
// (RULE12) Late command executes without delay
// (RULE13) Low-side current limit blanked after change
// (RULE14) Host drives high-side commands active low
// (RULE15) Host drives low-side commands active high
// (RULE16) High side refused until low side once
// (RULE17) Reset clears gates, counters, lock

module tdc_top (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // Enables
  input wire logic enable_i,
  // Phase commands
  input wire logic phase_a_high_command_n_i,
  input wire logic phase_a_low_command_i,
  input wire logic phase_b_high_command_n_i,
  input wire logic phase_b_low_command_i,
  input wire logic phase_c_high_command_n_i,
  input wire logic phase_c_low_command_i,
  // Fault inputs: overcurrent, desaturation, phase error
  input wire logic [2:0] fault_i,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Gate requests {c,b,a}
  output logic [2:0] hs_gate_o,
  output logic [2:0] ls_gate_o,
  output logic [2:0] blank_o,
  output logic irq_o
);
  import tdc_pkg::*;
  // ************************************************************
  // Configuration registers
  // ************************************************************
  tdc_dt_type dt_reg;           // Requested dead-time steps
  logic [7:0] cal_reg;          // Calibration trim, 0x80 = unity
  logic [3:0] mode_reg;         // Simul, desat, zero dead-time, lock
  logic simul_set_reg;          // Simul bit already written once
  logic unlock_reg;             // Key written, arms simul write
  logic [2:0] fmask_reg;        // Fault report enables
  logic [2:0] status_reg;       // Sticky faults
  logic [2:0] int_en_reg;

  // Tick divider
  logic [5:0] step_cnt_reg;
  logic step_reg;
  logic ack_reg;                // Bus answer cycle

  // Internal nets
  tdc_dt_type dt_eff;           // Dead-time handed to the phases
  logic [15:0] dt_prod;         // Setting times calibration
  // Qualified bus strobes
  logic wr;
  logic rd;
  // Per-phase views {c,b,a}
  logic [2:0] hs_w;
  logic [2:0] ls_w;
  logic [2:0] bl_w;
  logic [2:0] seen_w;
  // Commands gathered {c,b,a}
  logic [2:0] hs_cmd_w;
  logic [2:0] ls_cmd_w;
  // Status update terms
  logic [2:0] clr_w;
  logic [2:0] rep_w;

  // A write lands where waitrequest is seen low; a read is fetched in
  // the wait cycle, so its data stand at that same edge
  assign wr = avs_write && ack_reg;
  assign rd = avs_read && !ack_reg;

  // Calibrated dead-time, clamped to 12 us; zero mode forces none
  // cal_reg is a fraction with 0x80 as one
  assign dt_prod = dt_reg * cal_reg;
  always_comb begin
    dt_eff = dt_prod[14:7];                              // see (RULE2)
    // Bit 15 set means far beyond range
    if (dt_prod[15] || dt_prod[14:7] > 8'(`TDC_DT_MAX_STEPS)) begin
      dt_eff = 8'(`TDC_DT_MAX_STEPS);                    // see (RULE1)
    end
    // Zero mode overrides setting and calibration
    if (mode_reg[`TDC_MODE_ZERO_DT]) dt_eff = 8'h00;
  end

  // 50 ns tick divider; an enable pulse, so all stays on one clock
  // Wraps after one step's worth of cycles
  always_ff @(posedge mclk_i) begin
    if (reset_i || step_cnt_reg == 6'(`TDC_DT_STEP_CYC - 1)) begin
      step_cnt_reg <= 6'h00;
    end else begin
      step_cnt_reg <= step_cnt_reg + 6'h01;
    end
  end

  // Registered tick shared by all three phases
  always_ff @(posedge mclk_i) begin
    if (reset_i) step_reg <= 1'b0;
    else step_reg <= (step_cnt_reg == 6'(`TDC_DT_STEP_CYC - 1)); // see (RULE1)
  end

  // ************************************************************
  // Register writes
  // ************************************************************
  // Dead-time and calibration
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      dt_reg <= `TDC_DT_RESET;
      cal_reg <= `TDC_CAL_RESET;
    end else if (wr && avs_address == `TDC_OFS_DEADTIME) begin
      dt_reg <= avs_writedata[7:0];                      // see (RULE1)
    end else if (wr && avs_address == `TDC_OFS_CALIB) begin
      cal_reg <= avs_writedata[7:0];                     // see (RULE2)
    end
  end

  // Unlock key must precede a simul-mode write
  // Any other write disarms it, so the key cannot linger
  always_ff @(posedge mclk_i) begin
    if (reset_i) unlock_reg <= 1'b0;
    else if (wr) unlock_reg <= (avs_address == `TDC_OFS_UNLOCK) &&
                               (avs_writedata == `TDC_UNLOCK_KEY); // see (RULE4)
  end

  // Modes: frozen once lock set; simul bit writable once per reset
  // The lock freezes every bit, simul included
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      mode_reg <= 4'h0;                                  // see (RULE17)
      simul_set_reg <= 1'b0;
    end else if (wr && avs_address == `TDC_OFS_MODE && !mode_reg[`TDC_MODE_LOCK]) begin
      mode_reg[2:1] <= avs_writedata[2:1];               // see (RULE5)
      mode_reg[`TDC_MODE_LOCK] <= avs_writedata[`TDC_MODE_LOCK];
      // Simul bit needs the key just before and no earlier take
      if (unlock_reg && !simul_set_reg) begin
        mode_reg[`TDC_MODE_SIMUL] <= avs_writedata[`TDC_MODE_SIMUL]; // see (RULE4)
        simul_set_reg <= 1'b1;
      end
    end
  end

  // Fault masks and interrupt enables
  // A cleared mask bit hides the fault from status and interrupt
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      fmask_reg <= 3'h7;
      int_en_reg <= 3'h0;
    end else if (wr && avs_address == `TDC_OFS_FMASK) begin
      fmask_reg <= avs_writedata[2:0];                   // see (RULE6)
    end else if (wr && avs_address == `TDC_OFS_INT_EN) begin
      int_en_reg <= avs_writedata[2:0];
    end
  end

  // Sticky status; a new fault wins over a clear
  // A fault held as a level sets its bit again at once
  // Clear strobe from the write-only register
  assign clr_w = (wr && avs_address == `TDC_OFS_INT_CLR) ? avs_writedata[2:0] : 3'h0;
  // Faults that pass the report mask
  assign rep_w = fault_i & fmask_reg;
  always_ff @(posedge mclk_i) begin
    if (reset_i) status_reg <= 3'h0;
    else status_reg <= (status_reg & ~clr_w) | rep_w;    // see (RULE6)
  end

  // Level interrupt, one cycle behind the status
  always_ff @(posedge mclk_i) begin
    if (reset_i) irq_o <= 1'b0;
    else irq_o <= |(status_reg & int_en_reg);
  end

  // ************************************************************
  // Bus answer: one wait cycle, then ack with registered data
  // ************************************************************
  // Ack stands one cycle per request; a held request is answered
  // again only after a cycle with ack low
  // Ack is low after reset, so a first request sees waitrequest high
  always_ff @(posedge mclk_i) begin
    if (reset_i) ack_reg <= 1'b0;
    else ack_reg <= (avs_read || avs_write) && !ack_reg;
  end

  // Combinational on purpose: a registered waitrequest would cost
  // a second wait cycle on every access
  always_comb avs_waitrequest = (avs_read || avs_write) && !ack_reg;

  // Read data registered in the wait cycle, held until the next read
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      avs_readdata <= 32'h0000_0000;
    end else if (rd) begin
      unique case (avs_address)
        `TDC_OFS_DEADTIME: avs_readdata <= {24'h0, dt_reg};
        `TDC_OFS_CALIB: avs_readdata <= {24'h0, cal_reg};
        `TDC_OFS_MODE: avs_readdata <= {28'h0, mode_reg};
        `TDC_OFS_FMASK: avs_readdata <= {29'h0, fmask_reg};
        `TDC_OFS_STATUS: avs_readdata <= {29'h0, status_reg}; // see (RULE7)
        `TDC_OFS_INT_EN: avs_readdata <= {29'h0, int_en_reg};
        `TDC_OFS_GATES: avs_readdata <= {20'h0, seen_w, bl_w, ls_w, hs_w}; // see (RULE7)
        // Write-only and unmapped offsets read as zero, so a stray
        // read never shows old data
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // ************************************************************
  // Phase channels
  // ************************************************************
  // Inputs assumed driven to their documented polarity by the host;
  // they are taken as synchronous, with no resynchronising stage
  assign hs_cmd_w = {phase_c_high_command_n_i, phase_b_high_command_n_i,
                     phase_a_high_command_n_i};           // see (RULE14)
  assign ls_cmd_w = {phase_c_low_command_i, phase_b_low_command_i,
                     phase_a_low_command_i};              // see (RULE15)

  // Three identical channels, each with its own bundle
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_ph
      // Bundle fed from the pins and read back for status
      tdc_phase_if pif ();
      assign pif.hs_cmd_n = hs_cmd_w[g];
      assign pif.ls_cmd = ls_cmd_w[g];
      assign hs_w[g] = pif.hs_gate;
      assign ls_w[g] = pif.ls_gate;
      assign bl_w[g] = pif.blank;
      assign seen_w[g] = pif.ls_seen;
      // Enable low empties the channel
      tdc_phase u_ph (
        .mclk_i(mclk_i),
        .reset_i(reset_i),
        .step_i(step_reg),
        .dt_i(dt_eff),
        .simul_i(mode_reg[`TDC_MODE_SIMUL]),
        .en_i(enable_i),
        .ph(pif)
      );
    end
  endgenerate

  // Output registers; reset holds all gates off
  // This stage adds one cycle to every gate edge at the pins
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      hs_gate_o <= 3'h0;                                 // see (RULE17)
      ls_gate_o <= 3'h0;
      blank_o <= 3'h0;
    end else begin
      hs_gate_o <= hs_w;
      ls_gate_o <= ls_w;
      blank_o <= bl_w;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  // Nothing of the mode moves once locked
  lock_hold_a: assert property (@(posedge mclk_i) disable iff (reset_i) // see (RULE5)
    $past(mode_reg[`TDC_MODE_LOCK]) |-> $stable(mode_reg)) else $error("locked mode changed");
  // Simul bit taken at most once per reset
  simul_once_a: assert property (@(posedge mclk_i) disable iff (reset_i) // see (RULE4)
    $past(simul_set_reg) |-> $stable(mode_reg[`TDC_MODE_SIMUL])) else $error("simul changed twice");
  // A reported fault on source 0 always reaches status
  stat_set_a: assert property (@(posedge mclk_i) disable iff (reset_i) // see (RULE6)
    (fault_i[0] && fmask_reg[0]) |=> status_reg[0]) else $error("fault lost");
  // A suppressed fault on source 0 never does
  stat_mask_a: assert property (@(posedge mclk_i) disable iff (reset_i) // see (RULE6)
    (!status_reg[0] && !(fault_i[0] && fmask_reg[0])) |=> !status_reg[0])
    else $error("masked fault set");
  // Effective dead-time never above 12 us
  dt_clamp_a: assert property (@(posedge mclk_i) disable iff (reset_i) // see (RULE1)
    dt_eff <= 8'(`TDC_DT_MAX_STEPS)) else $error("dead-time over range");
  // Status read returns the live value
  rd_back_a: assert property (@(posedge mclk_i) disable iff (reset_i) // see (RULE7)
    (rd && avs_address == `TDC_OFS_STATUS) |=> avs_readdata[2:0] == $past(status_reg))
    else $error("status read wrong");

  // Main scenarios
  cv_lock_c: cover property (@(posedge mclk_i) $rose(mode_reg[`TDC_MODE_LOCK]));
  cv_irq_c: cover property (@(posedge mclk_i) $rose(irq_o));
  cv_simul_c: cover property (@(posedge mclk_i) $rose(mode_reg[`TDC_MODE_SIMUL]));
endmodule : tdc_top
`default_nettype wire

// file: testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "tdc_map.svh"
// ************************************************************
// Bench for the dead-time controller
// ************************************************************
module testbench;
  // Design inputs, all valued at time zero
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic enable_i = 1'b0;
  logic [2:0] fault_i = 3'h0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  // Design outputs
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [2:0] hs_gate_o, ls_gate_o, blank_o;
  logic irq_o;
  // Host command wires {c,b,a}
  logic [2:0] hs_cmd_n, ls_cmd;
  // Bookkeeping
  int errors = 0;
  int cmp_count = 0;
  int n;
  int eff;
  logic [31:0] rd;
  // Dead-time setting of 500 ns; calibration differs per phase
  localparam logic [7:0] DT = 8'h0a;
  logic [7:0] cal_tab [3] = '{8'h80, 8'h40, 8'hc0};

  // Free-running 40 MHz clock
  initial begin
    forever #12.5 mclk_i = ~mclk_i;
  end

  tdc_host_model host (.mclk_i(mclk_i), .high_side_command_n_o(hs_cmd_n),
    .low_side_command_o(ls_cmd));

  tdc_top uut (.mclk_i(mclk_i), .reset_i(reset_i), .enable_i(enable_i),
    .phase_a_high_command_n_i(hs_cmd_n[0]), .phase_a_low_command_i(ls_cmd[0]),
    .phase_b_high_command_n_i(hs_cmd_n[1]), .phase_b_low_command_i(ls_cmd[1]),
    .phase_c_high_command_n_i(hs_cmd_n[2]), .phase_c_low_command_i(ls_cmd[2]),
    .fault_i(fault_i), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .hs_gate_o(hs_gate_o), .ls_gate_o(ls_gate_o), .blank_o(blank_o),
    .irq_o(irq_o));

  // ************************************************************
  // Shared tasks
  // ************************************************************
  // Compare and count; four-state equality so X never matches
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
    end
  endtask : check

  // Count within a window
  task automatic win(input int k, input int lo, input int hi);
    check(32'(k >= lo && k <= hi), 32'h1);
  endtask : win

  // One Avalon transfer; held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int k;
    k = 0;
    @(posedge mclk_i);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    do begin
      @(posedge mclk_i);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 40);
    q = avs_readdata;
    if (k >= 40) errors++;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rd);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, rd);
    check(rd, exp);
  endtask : rd_chk

  // Edges until a gate request is seen high; bounded
  task automatic wait_rise(input int ph, input logic hs, output int k);
    k = 0;
    do begin
      @(posedge mclk_i);
      k++;
    end while ((hs ? hs_gate_o[ph] : ls_gate_o[ph]) !== 1'b1 && k < 700);
  endtask : wait_rise

  // One-cycle fault event, then a few cycles to settle
  task automatic pulse(input logic [2:0] f);
    @(posedge mclk_i);
    fault_i <= f;
    @(posedge mclk_i);
    fault_i <= 3'h0;
    repeat (3) @(posedge mclk_i);
  endtask : pulse

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up

  // Watchdog: the tests need under a thousand cycles
  initial begin
    #(25 * 30000);
    errors++;
    wrap_up();
  end

  // ************************************************************
  // Test sequence
  // ************************************************************
  initial begin
    repeat (5) @(posedge mclk_i);
    check(32'({hs_gate_o, ls_gate_o, blank_o}), 32'h0);
    reset_i <= 1'b0;
    // Reset values; an unmapped write must leave no trace
    wr(8'h40, 32'hffff_ffff);
    rd_chk(`TDC_OFS_DEADTIME, 32'(`TDC_DT_RESET));
    rd_chk(`TDC_OFS_CALIB, 32'(`TDC_CAL_RESET));
    rd_chk(`TDC_OFS_FMASK, 32'h7);
    rd_chk(`TDC_OFS_MODE, 32'h0);
    rd_chk(`TDC_OFS_STATUS, 32'h0);
    rd_chk(8'h40, 32'h0);
    wr(`TDC_OFS_DEADTIME, 32'd240);
    rd_chk(`TDC_OFS_DEADTIME, 32'd240);
    wr(`TDC_OFS_DEADTIME, 32'(DT));
    $display("Test registers done");
    // Each phase with its own calibration factor
    enable_i <= 1'b1;
    for (int ph = 0; ph < 3; ph++) begin
      wr(`TDC_OFS_CALIB, 32'(cal_tab[ph]));
      eff = (int'(DT) * int'(cal_tab[ph])) / 128;
      host.cmd(ph, 1'b1, 1'b0);
      repeat (40) @(posedge mclk_i);
      check(32'(hs_gate_o[ph]), 32'h0);
      host.cmd(ph, 1'b0, 1'b0);
      repeat (2 * eff + 10) @(posedge mclk_i);
      // Dead-time long over: low side comes at once, blanked
      host.cmd(ph, 1'b0, 1'b1);
      wait_rise(ph, 1'b0, n);
      win(n, 1, 4);
      repeat (2) @(posedge mclk_i);
      check(32'(blank_o[ph]), 32'h1);
      repeat (`TDC_BLANK_CYC + 10) @(posedge mclk_i);
      check(32'(blank_o[ph]), 32'h0);
      // High-side edge with low side still held
      host.cmd(ph, 1'b1, 1'b1);
      repeat (4) @(posedge mclk_i);
      check(32'(ls_gate_o[ph]), 32'h0);
      wait_rise(ph, 1'b1, n);
      win(n + 4, 2 * eff, 2 * eff + 8);
      check(32'(ls_gate_o[ph]), 32'h0);
      // High side released, low side asked for right behind it
      host.cmd(ph, 1'b0, 1'b0);
      host.cmd(ph, 1'b0, 1'b1);
      wait_rise(ph, 1'b0, n);
      win(n + 1, 2 * eff, 2 * eff + 8);
      host.cmd(ph, 1'b0, 1'b0);
      repeat (2 * eff + 10) @(posedge mclk_i);
      $display("Test phase %0d done", ph);
    end
    // Fault reporting, interrupt enable and clear
    wr(`TDC_OFS_FMASK, 32'h6);
    wr(`TDC_OFS_INT_EN, 32'h7);
    pulse(3'h1);
    rd_chk(`TDC_OFS_STATUS, 32'h0);
    check(32'(irq_o), 32'h0);
    wr(`TDC_OFS_FMASK, 32'h7);
    pulse(3'h3);
    rd_chk(`TDC_OFS_STATUS, 32'h3);
    check(32'(irq_o), 32'h1);
    wr(`TDC_OFS_INT_EN, 32'h0);
    repeat (3) @(posedge mclk_i);
    check(32'(irq_o), 32'h0);
    wr(`TDC_OFS_INT_EN, 32'h7);
    wr(`TDC_OFS_INT_CLR, 32'h3);
    rd_chk(`TDC_OFS_STATUS, 32'h0);
    check(32'(irq_o), 32'h0);
    $display("Test faults done");
    // Simultaneous mode: key needed, taken once, then locked
    wr(`TDC_OFS_MODE, 32'h1);
    rd_chk(`TDC_OFS_MODE, 32'h0);
    wr(`TDC_OFS_UNLOCK, `TDC_UNLOCK_KEY);
    wr(`TDC_OFS_MODE, 32'h1);
    rd_chk(`TDC_OFS_MODE, 32'h1);
    wr(`TDC_OFS_UNLOCK, `TDC_UNLOCK_KEY);
    wr(`TDC_OFS_MODE, 32'h0);
    rd_chk(`TDC_OFS_MODE, 32'h1);
    host.cmd(0, 1'b0, 1'b1);
    host.cmd(0, 1'b1, 1'b1);
    repeat (10) @(posedge mclk_i);
    check(32'({hs_gate_o[0], ls_gate_o[0], blank_o[0]}), 32'h6);
    rd_chk(`TDC_OFS_GATES, 32'he09);
    wr(`TDC_OFS_MODE, 32'hb);
    rd_chk(`TDC_OFS_MODE, 32'hb);
    wr(`TDC_OFS_UNLOCK, `TDC_UNLOCK_KEY);
    wr(`TDC_OFS_MODE, 32'h4);
    rd_chk(`TDC_OFS_MODE, 32'hb);
    $display("Test modes done");
    // Second reset in mid-run with gates on
    reset_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    check(32'({hs_gate_o, ls_gate_o, blank_o}), 32'h0);
    reset_i <= 1'b0;
    rd_chk(`TDC_OFS_MODE, 32'h0);
    wr(`TDC_OFS_UNLOCK, `TDC_UNLOCK_KEY);
    wr(`TDC_OFS_MODE, 32'h1);
    rd_chk(`TDC_OFS_MODE, 32'h1);
    $display("Test second reset done");
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
